// [design/pmr_pkg.sv]
// Purpose: constants for the pcs management register bank
// Assumes: byte-wide host bus with 5-bit address
// Notes: offsets are byte addresses on the host bus
package pmr_pkg;

    // ==========================================================
    // host bus offsets
    localparam logic [4:0] PMR_OFS_CTRL_LO = 5'h00;
    localparam logic [4:0] PMR_OFS_CTRL_HI = 5'h01;
    localparam logic [4:0] PMR_OFS_STAT_LO = 5'h02;
    localparam logic [4:0] PMR_OFS_STAT_HI = 5'h03;
    localparam logic [4:0] PMR_OFS_ADV_LO = 5'h08;
    localparam logic [4:0] PMR_OFS_ADV_HI = 5'h09;
    localparam logic [4:0] PMR_OFS_PEER_LO = 5'h0a;
    localparam logic [4:0] PMR_OFS_PEER_HI = 5'h0b;
    localparam logic [4:0] PMR_OFS_EXP_LO = 5'h0c;
    localparam logic [4:0] PMR_OFS_EXP_HI = 5'h0d;
    localparam logic [4:0] PMR_OFS_EXT_LO = 5'h1e;
    localparam logic [4:0] PMR_OFS_EXT_HI = 5'h1f;

    // ==========================================================
    // control high byte fields
    localparam int PMR_CH_RESET = 7;
    localparam int PMR_CH_LOOP = 6;
    localparam int PMR_CH_RATE0 = 5;
    localparam int PMR_CH_ANEN = 4;
    localparam int PMR_CH_PDOWN = 3;
    localparam int PMR_CH_ISO = 2;
    localparam int PMR_CH_RESTART = 1;
    localparam int PMR_CH_DUPLEX = 0;
    // control low byte fields
    localparam int PMR_CL_RATE1 = 6;
    localparam int PMR_CL_UNIDIR = 5;
    // writable mask of control low: only rate1 and unidirectional
    localparam logic [7:0] PMR_CL_MASK = 8'h60;

    // ==========================================================
    // fixed values and reset values
    localparam logic [15:0] PMR_EXT_STATUS = 16'h8000;
    localparam logic [7:0] PMR_RST_CTRL_HI = 8'h10;
    localparam logic [7:0] PMR_RST_CTRL_LO = 8'h40;
    localparam logic [7:0] PMR_RST_ADV_LO = 8'h00;
    localparam logic [7:0] PMR_RST_ADV_HI = 8'h00;
    localparam int PMR_ADV_RATE_LSB = 10;

    // ==========================================================
    // rate encoding
    typedef enum logic [1:0] {
        PMR_RATE_10M = 2'b00,
        PMR_RATE_100M = 2'b01,
        PMR_RATE_1G = 2'b10,
        PMR_RATE_RSVD = 2'b11
    } pmr_rate_t;

endpackage : pmr_pkg

// [design/pmr_rate_sel.sv]
// Purpose: picks the media-independent data rate
// Assumes: inputs are registered control bits on ref_clk
// Notes: purely combinational
`timescale 1ns/10ps
module pmr_rate_sel
    import pmr_pkg::*;
(
    // mode and control
    input wire logic sgmii_mode,
    input wire logic an_enable,
    input wire logic [1:0] ctrl_rate,
    input wire logic [1:0] adv_rate,
    // decoded rate
    output pmr_rate_t mii_rate,
    output logic rate_is_1g,
    output logic rate_is_100m,
    output logic rate_is_10m
);

    // gbe is always gigabit; sgmii follows negotiation or control
    always_comb begin
        if (!sgmii_mode) begin
            mii_rate = PMR_RATE_1G;
        end else if (an_enable) begin
            mii_rate = pmr_rate_t'(adv_rate);
        end else begin
            mii_rate = pmr_rate_t'(ctrl_rate);
        end
    end

    // reserved code selects no rate at all
    assign rate_is_1g = (mii_rate == PMR_RATE_1G);
    assign rate_is_100m = (mii_rate == PMR_RATE_100M);
    assign rate_is_10m = (mii_rate == PMR_RATE_10M);

endmodule : pmr_rate_sel

// [design/pmr_regs.sv]
// Purpose: management register bank of a gigabit / sgmii pcs
// Assumes: host bus is byte wide, one-cycle write strobe, read data
//          registered one cycle after the read strobe
// Notes: status, peer ability and expansion bits come in as inputs
`timescale 1ns/10ps

module pmr_regs
    import pmr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // configuration
    input wire logic sgmii_mode,
    // host bus
    input wire logic [4:0] hb_addr,
    input wire logic hb_wr,
    input wire logic hb_rd,
    input wire logic [7:0] hb_wdata,
    output logic [7:0] hb_rdata,
    output logic hb_ack,
    // state inputs from the sublayer
    input wire logic [15:0] status_in,
    input wire logic [15:0] peer_ability_in,
    input wire logic [15:0] expansion_in,
    // 16-bit extended status on the serial management side
    output logic [15:0] ext_status_smi,
    // control outputs
    output logic pcs_reset,
    output logic an_restart,
    output logic loopback,
    output logic an_enable,
    output logic power_down,
    output logic isolate,
    output logic duplex_full,
    output logic unidirectional,
    output logic [15:0] adv_ability,
    output pmr_rate_t mii_rate,
    output logic rate_is_1g,
    output logic rate_is_100m,
    output logic rate_is_10m
);

    // ==========================================================
    // storage
    logic [7:0] ctrl_hi_ff;
    logic [7:0] ctrl_lo_ff;
    logic [7:0] adv_lo_ff;
    logic [7:0] adv_hi_ff;
    logic [7:0] hb_rdata_ff;
    logic hb_ack_ff;
    logic [7:0] nxt_ctrl_hi;
    logic [7:0] nxt_ctrl_lo;
    logic [7:0] nxt_rdata;
    logic [1:0] ctrl_rate;

    // one place for address compare so all write decodes agree
    function automatic logic pmr_hit(input logic [4:0] a, input logic [4:0] ofs);
        pmr_hit = (a == ofs);
    endfunction : pmr_hit

    // extended status is constant, so writes can never disturb it
    assign ext_status_smi = PMR_EXT_STATUS;

    // ==========================================================
    // control high next value; self-clearing bits last one cycle
    always_comb begin
        nxt_ctrl_hi = ctrl_hi_ff;
        nxt_ctrl_hi[PMR_CH_RESET] = 1'b0;
        nxt_ctrl_hi[PMR_CH_RESTART] = 1'b0;
        if (hb_wr && pmr_hit(hb_addr, PMR_OFS_CTRL_HI)) begin
            nxt_ctrl_hi = hb_wdata;
        end
        // gbe pins rate bit 0 at zero
        if (!sgmii_mode) begin
            nxt_ctrl_hi[PMR_CH_RATE0] = 1'b0;
        end
    end

    // control low next value; only rate1 and unidirectional store
    always_comb begin
        nxt_ctrl_lo = ctrl_lo_ff;
        if (hb_wr && pmr_hit(hb_addr, PMR_OFS_CTRL_LO)) begin
            nxt_ctrl_lo = hb_wdata & PMR_CL_MASK;
        end
        if (!sgmii_mode) begin
            nxt_ctrl_lo[PMR_CL_RATE1] = 1'b1;
        end
    end

    // control registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_hi_ff <= PMR_RST_CTRL_HI;
            ctrl_lo_ff <= PMR_RST_CTRL_LO;
        end else begin
            ctrl_hi_ff <= nxt_ctrl_hi;
            ctrl_lo_ff <= nxt_ctrl_lo;
        end
    end

    // advertised ability registers, fully writable
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            adv_lo_ff <= PMR_RST_ADV_LO;
            adv_hi_ff <= PMR_RST_ADV_HI;
        end else if (hb_wr && pmr_hit(hb_addr, PMR_OFS_ADV_LO)) begin
            adv_lo_ff <= hb_wdata;
        end else if (hb_wr && pmr_hit(hb_addr, PMR_OFS_ADV_HI)) begin
            adv_hi_ff <= hb_wdata;
        end
    end

    // ==========================================================
    // control outputs straight from the flops
    assign pcs_reset = ctrl_hi_ff[PMR_CH_RESET];
    assign an_restart = ctrl_hi_ff[PMR_CH_RESTART];
    assign loopback = ctrl_hi_ff[PMR_CH_LOOP];
    assign an_enable = ctrl_hi_ff[PMR_CH_ANEN];
    assign power_down = ctrl_hi_ff[PMR_CH_PDOWN];
    assign isolate = ctrl_hi_ff[PMR_CH_ISO];
    // duplex is reported only; the channel keeps split tx and rx paths
    assign duplex_full = ctrl_hi_ff[PMR_CH_DUPLEX];
    assign unidirectional = ctrl_lo_ff[PMR_CL_UNIDIR];
    assign adv_ability = {adv_hi_ff, adv_lo_ff};
    assign ctrl_rate = {ctrl_lo_ff[PMR_CL_RATE1], ctrl_hi_ff[PMR_CH_RATE0]};

    // rate selection
    pmr_rate_sel u_rate (
        .sgmii_mode(sgmii_mode),
        .an_enable(an_enable),
        .ctrl_rate(ctrl_rate),
        .adv_rate(adv_ability[PMR_ADV_RATE_LSB+1:PMR_ADV_RATE_LSB]),
        .mii_rate(mii_rate),
        .rate_is_1g(rate_is_1g),
        .rate_is_100m(rate_is_100m),
        .rate_is_10m(rate_is_10m)
    );

    // ==========================================================
    // read mux; unmapped addresses read as zero
    always_comb begin
        case (hb_addr)
            PMR_OFS_CTRL_LO: nxt_rdata = ctrl_lo_ff;
            PMR_OFS_CTRL_HI: nxt_rdata = ctrl_hi_ff;
            PMR_OFS_STAT_LO: nxt_rdata = status_in[7:0];
            PMR_OFS_STAT_HI: nxt_rdata = status_in[15:8];
            PMR_OFS_ADV_LO: nxt_rdata = adv_lo_ff;
            PMR_OFS_ADV_HI: nxt_rdata = adv_hi_ff;
            PMR_OFS_PEER_LO: nxt_rdata = peer_ability_in[7:0];
            PMR_OFS_PEER_HI: nxt_rdata = peer_ability_in[15:8];
            PMR_OFS_EXP_LO: nxt_rdata = expansion_in[7:0];
            PMR_OFS_EXP_HI: nxt_rdata = expansion_in[15:8];
            PMR_OFS_EXT_LO: nxt_rdata = PMR_EXT_STATUS[7:0];
            PMR_OFS_EXT_HI: nxt_rdata = PMR_EXT_STATUS[15:8];
            default: nxt_rdata = 8'h00;
        endcase
    end

    // read data is held until the next read
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hb_rdata_ff <= 8'h00;
            hb_ack_ff <= 1'b0;
        end else begin
            hb_ack_ff <= hb_rd | hb_wr;
            if (hb_rd) begin
                hb_rdata_ff <= nxt_rdata;
            end
        end
    end

    assign hb_rdata = hb_rdata_ff;
    assign hb_ack = hb_ack_ff;

    // ==========================================================
    // checks
    property p_ext_fixed;
        @(posedge ref_clk) disable iff (srst)
        ext_status_smi[15] && (ext_status_smi[14:0] == 15'h0000);
    endproperty
    a_ext_fixed: assert property (p_ext_fixed) else $error("ext status not fixed");

    property p_ext_read;
        @(posedge ref_clk) disable iff (srst)
        (hb_rd && hb_addr == PMR_OFS_EXT_HI) |=> (hb_rdata == 8'h80);
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("ext high read wrong");

    property p_reset_selfclr;
        @(posedge ref_clk) disable iff (srst)
        pcs_reset |=>
            (!pcs_reset || $past(hb_wr && hb_addr == PMR_OFS_CTRL_HI && hb_wdata[PMR_CH_RESET]));
    endproperty
    a_reset_selfclr: assert property (p_reset_selfclr) else $error("reset stuck");

    property p_restart_pulse;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_CTRL_HI && hb_wdata[PMR_CH_RESTART])
            ##1 !hb_wr |-> an_restart ##1 !an_restart;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart not pulse");

    property p_loop_write;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_CTRL_HI) |=> (loopback == $past(hb_wdata[PMR_CH_LOOP]));
    endproperty
    a_loop_write: assert property (p_loop_write) else $error("loopback not stored");

    property p_pdown_write;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_CTRL_HI) |=> (power_down == $past(hb_wdata[PMR_CH_PDOWN]));
    endproperty
    a_pdown_write: assert property (p_pdown_write) else $error("power down not stored");

    property p_gbe_rate;
        @(posedge ref_clk) disable iff (srst)
        !sgmii_mode |-> (mii_rate == PMR_RATE_1G) && rate_is_1g;
    endproperty
    a_gbe_rate: assert property (p_gbe_rate) else $error("gbe rate not gigabit");

    property p_sgmii_an_rate;
        @(posedge ref_clk) disable iff (srst)
        (sgmii_mode && an_enable) |-> (mii_rate == adv_ability[11:10]);
    endproperty
    a_sgmii_an_rate: assert property (p_sgmii_an_rate) else $error("rate not advertised");

    property p_sgmii_ctrl_rate;
        @(posedge ref_clk) disable iff (srst)
        (sgmii_mode && !an_enable) |-> (mii_rate == ctrl_rate);
    endproperty
    a_sgmii_ctrl_rate: assert property (p_sgmii_ctrl_rate) else $error("rate not ctrl");

    property p_ctrl_lo_zeros;
        @(posedge ref_clk) disable iff (srst)
        (ctrl_lo_ff & ~PMR_CL_MASK) == 8'h00;
    endproperty
    a_ctrl_lo_zeros: assert property (p_ctrl_lo_zeros) else $error("ctrl low bit set");

    // self-clearing bits and gbe-pinned rate bits may move on their own, so mask them
    property p_ro_ignored;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_EXT_LO) |=>
            $stable(ctrl_hi_ff & 8'h5d) && $stable(ctrl_lo_ff & 8'h20) && $stable(adv_ability);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write leaked");

    // ==========================================================
    // bus handshake, decode and field placement checks
    property p_ack_pulse;
        @(posedge ref_clk) disable iff (srst)
        (hb_rd || hb_wr) |=> hb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack missing");

    property p_ack_idle;
        @(posedge ref_clk) disable iff (srst)
        !(hb_rd || hb_wr) |=> !hb_ack;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

    property p_adv_lo_write;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_ADV_LO) |=> (adv_ability[7:0] == $past(hb_wdata));
    endproperty
    a_adv_lo_write: assert property (p_adv_lo_write) else $error("adv low not stored");

    property p_adv_hi_write;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_ADV_HI) |=> (adv_ability[15:8] == $past(hb_wdata));
    endproperty
    a_adv_hi_write: assert property (p_adv_hi_write) else $error("adv high not stored");

    property p_stat_read;
        @(posedge ref_clk) disable iff (srst)
        (hb_rd && hb_addr == PMR_OFS_STAT_LO) |=> (hb_rdata == $past(status_in[7:0]));
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status low read wrong");

    property p_peer_read;
        @(posedge ref_clk) disable iff (srst)
        (hb_rd && hb_addr == PMR_OFS_PEER_HI) |=> (hb_rdata == $past(peer_ability_in[15:8]));
    endproperty
    a_peer_read: assert property (p_peer_read) else $error("peer high read wrong");

    property p_exp_read;
        @(posedge ref_clk) disable iff (srst)
        (hb_rd && hb_addr == PMR_OFS_EXP_LO) |=> (hb_rdata == $past(expansion_in[7:0]));
    endproperty
    a_exp_read: assert property (p_exp_read) else $error("expansion low read wrong");

    property p_reset_set;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_CTRL_HI && hb_wdata[PMR_CH_RESET]) |=> pcs_reset;
    endproperty
    a_reset_set: assert property (p_reset_set) else $error("reset not set");

    property p_duplex_write;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_CTRL_HI) |=> (duplex_full == $past(hb_wdata[PMR_CH_DUPLEX]));
    endproperty
    a_duplex_write: assert property (p_duplex_write) else $error("duplex not stored");

    property p_unidir_write;
        @(posedge ref_clk) disable iff (srst)
        (hb_wr && hb_addr == PMR_OFS_CTRL_LO) |=>
            (unidirectional == $past(hb_wdata[PMR_CL_UNIDIR]));
    endproperty
    a_unidir_write: assert property (p_unidir_write) else $error("unidir not stored");

    // a gbe write of zero to rate1 or of one to rate0 must not show up on readback
    property p_gbe_pinned;
        @(posedge ref_clk) disable iff (srst)
        !sgmii_mode |=> ctrl_lo_ff[PMR_CL_RATE1] && !ctrl_hi_ff[PMR_CH_RATE0];
    endproperty
    a_gbe_pinned: assert property (p_gbe_pinned) else $error("gbe rate bits moved");

    property p_rate_bits;
        @(posedge ref_clk) disable iff (srst)
        (sgmii_mode && !an_enable) |->
            (mii_rate == {ctrl_lo_ff[PMR_CL_RATE1], ctrl_hi_ff[PMR_CH_RATE0]});
    endproperty
    a_rate_bits: assert property (p_rate_bits) else $error("rate bits misplaced");

    property p_rsvd_none;
        @(posedge ref_clk) disable iff (srst)
        (mii_rate == PMR_RATE_RSVD) |-> !(rate_is_1g || rate_is_100m || rate_is_10m);
    endproperty
    a_rsvd_none: assert property (p_rsvd_none) else $error("reserved rate decoded");

    property p_rate_onehot;
        @(posedge ref_clk) disable iff (srst)
        (mii_rate != PMR_RATE_RSVD) |-> $onehot({rate_is_1g, rate_is_100m, rate_is_10m});
    endproperty
    a_rate_onehot: assert property (p_rate_onehot) else $error("rate decode not one-hot");

    c_reset_write: cover property (@(posedge ref_clk) disable iff (srst) pcs_reset);
    c_sgmii_an: cover property (@(posedge ref_clk) disable iff (srst) sgmii_mode && an_enable);
    c_rate_100m: cover property (@(posedge ref_clk) disable iff (srst) rate_is_100m);
    c_rate_rsvd: cover property (@(posedge ref_clk) disable iff (srst) mii_rate == PMR_RATE_RSVD);
    c_ext_read: cover property (@(posedge ref_clk) disable iff (srst)
        hb_rd && hb_addr == PMR_OFS_EXT_HI);

endmodule : pmr_regs

// [dv/pmr_host_model.sv]
// Purpose: host controller model for the byte-wide register bus
// Assumes: calls start 1 ns after a rising edge of ref_clk
// Notes: one request per call after one idle edge; ack and read data are taken one edge later
`timescale 1ns/10ps
module pmr_host_model (
    // clock
    input wire logic ref_clk,
    // host bus
    output logic [4:0] hb_addr,
    output logic hb_wr,
    output logic hb_rd,
    output logic [7:0] hb_wdata,
    input wire logic [7:0] hb_rdata,
    input wire logic hb_ack
);
    // ============================================================
    // idle bus with both strobes low
    initial begin
        hb_addr = 5'h00;
        hb_wr = 1'b0;
        hb_rd = 1'b0;
        hb_wdata = 8'h00;
    end

    // ============================================================
    // one strobe cycle; stale address and data are inverted afterwards
    // so a design that samples them without a strobe shows up wrong
    task automatic access(input logic is_wr, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ack);
        // an idle edge first, so a strobe never drops and rises in one step
        @(posedge ref_clk);
        #1;
        hb_addr = a;
        hb_wdata = d;
        hb_wr = is_wr;
        hb_rd = !is_wr;
        @(posedge ref_clk);
        #1;
        q = hb_rdata;
        ack = hb_ack;
        hb_wr = 1'b0;
        hb_rd = 1'b0;
        hb_addr = ~a;
        hb_wdata = ~d;
    endtask : access
endmodule : pmr_host_model

// [dv/pmr_regs_bench.sv]
// Purpose: self-checking bench for the pcs management register bank
// Assumes: host model drives the bus; bench drives mode and sublayer state
// Notes: every access is checked for its one-cycle ack
`timescale 1ns/10ps
module pmr_regs_bench;
    import pmr_pkg::*;
    logic ref_clk, srst, sgmii_mode, hb_wr, hb_rd, hb_ack, pcs_reset, an_restart;
    logic loopback, an_enable, power_down, isolate, duplex_full, unidirectional;
    logic rate_is_1g, rate_is_100m, rate_is_10m;
    logic [4:0] hb_addr;
    logic [7:0] hb_wdata, hb_rdata;
    logic [15:0] status_in, peer_ability_in, expansion_in, ext_status_smi, adv_ability;
    logic [1:0] r;
    pmr_rate_t mii_rate;
    int n_fail = 0;
    int total_checks = 0;

    // ============================================================
    // design and host
    pmr_regs u_pmr_regs (.ref_clk(ref_clk), .srst(srst), .sgmii_mode(sgmii_mode),
        .hb_addr(hb_addr), .hb_wr(hb_wr), .hb_rd(hb_rd), .hb_wdata(hb_wdata),
        .hb_rdata(hb_rdata), .hb_ack(hb_ack), .status_in(status_in),
        .peer_ability_in(peer_ability_in), .expansion_in(expansion_in),
        .ext_status_smi(ext_status_smi), .pcs_reset(pcs_reset), .an_restart(an_restart),
        .loopback(loopback), .an_enable(an_enable), .power_down(power_down),
        .isolate(isolate), .duplex_full(duplex_full), .unidirectional(unidirectional),
        .adv_ability(adv_ability), .mii_rate(mii_rate), .rate_is_1g(rate_is_1g),
        .rate_is_100m(rate_is_100m), .rate_is_10m(rate_is_10m));
    pmr_host_model u_pmr_host_model (.ref_clk(ref_clk), .hb_addr(hb_addr), .hb_wr(hb_wr),
        .hb_rd(hb_rd), .hb_wdata(hb_wdata), .hb_rdata(hb_rdata), .hb_ack(hb_ack));

    // ============================================================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic ack;
        u_pmr_host_model.access(1'b1, a, d, q, ack);
        chk("hb_ack_wr", 16'h0001, {15'h0, ack});
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic ack;
        u_pmr_host_model.access(1'b0, a, 8'h00, q, ack);
        chk("hb_ack_rd", 16'h0001, {15'h0, ack});
        chk("hb_rdata", {8'h00, e}, {8'h00, q});
    endtask : rd
    // a decode flag for the reserved code 11 would be wrong, so all three are compared
    task automatic chk_rate(input logic [1:0] e);
        chk("mii_rate", {14'h0, e}, {14'h0, mii_rate});
        chk("rate_flags", {13'h0, e == 2'b10, e == 2'b01, e == 2'b00},
            {13'h0, rate_is_1g, rate_is_100m, rate_is_10m});
    endtask : chk_rate
    task automatic tally_and_finish;
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ============================================================
    // clock and watchdog; the tests need about 1.2 us
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #20000;
        n_fail++;
        tally_and_finish;
    end

    // ============================================================
    // test sequence
    initial begin
        srst = 1'b1;
        sgmii_mode = 1'b0;
        status_in = 16'ha5c3;
        peer_ability_in = 16'h5a3c;
        expansion_in = 16'h0002;
        repeat (8) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        rd(5'h01, 8'h10);
        rd(5'h00, 8'h40);
        rd(5'h08, 8'h00);
        chk("ext_status_smi", 16'h8000, ext_status_smi);
        wr(5'h1f, 8'h7f);
        wr(5'h1e, 8'hff);
        rd(5'h1f, 8'h80);
        rd(5'h1e, 8'h00);
        wr(5'h02, 8'hff);
        rd(5'h02, 8'hc3);
        rd(5'h03, 8'ha5);
        rd(5'h0a, 8'h3c);
        rd(5'h0b, 8'h5a);
        rd(5'h0c, 8'h02);
        rd(5'h0d, 8'h00);
        rd(5'h10, 8'h00);
        // control levels with rate bit set while pinned to gigabit
        wr(5'h01, 8'h7d);
        chk("ctrl_levels", 16'h001f,
            {loopback, an_enable, power_down, isolate, duplex_full});
        rd(5'h01, 8'h5d);
        chk_rate(2'b10);
        wr(5'h01, 8'h00);
        chk("ctrl_levels", 16'h0000,
            {loopback, an_enable, power_down, isolate, duplex_full});
        wr(5'h00, 8'hff);
        chk("unidirectional", 16'h0001, {15'h0, unidirectional});
        rd(5'h00, 8'h60);
        wr(5'h00, 8'h00);
        rd(5'h00, 8'h40);
        chk_rate(2'b10);
        // self-clearing pulses last exactly one cycle
        wr(5'h01, 8'h82);
        chk("pulses", 16'h0003, {14'h0, pcs_reset, an_restart});
        @(posedge ref_clk);
        #1;
        chk("pulses", 16'h0000, {14'h0, pcs_reset, an_restart});
        rd(5'h01, 8'h00);
        // sgmii without negotiation: control bits steer the rate
        sgmii_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            r = i[1:0];
            wr(5'h00, {1'b0, r[1], 6'h00});
            wr(5'h01, {2'b00, r[0], 5'h00});
            chk_rate(r);
            rd(5'h01, {2'b00, r[0], 5'h00});
            rd(5'h00, {1'b0, r[1], 6'h00});
        end
        // with negotiation on, advertised bits 11:10 steer it instead
        wr(5'h01, 8'h30);
        wr(5'h08, 8'ha5);
        for (int i = 0; i < 4; i++) begin
            r = 2'(3 - i);
            wr(5'h09, {4'h0, r, 2'b00});
            chk_rate(r);
            chk("adv_ability", {4'h0, r, 10'h0a5}, adv_ability);
        end
        rd(5'h08, 8'ha5);
        // back to plain gigabit: rate pinned again
        sgmii_mode = 1'b0;
        @(posedge ref_clk);
        #1;
        chk_rate(2'b10);
        rd(5'h01, 8'h10);
        rd(5'h00, 8'h40);
        // reset in mid-run brings the reset values back over non-reset contents
        wr(5'h09, 8'hff);
        wr(5'h01, 8'h4d);
        srst = 1'b1;
        @(posedge ref_clk);
        #1;
        srst = 1'b0;
        rd(5'h09, 8'h00);
        rd(5'h08, 8'h00);
        rd(5'h01, 8'h10);
        tally_and_finish;
    end
endmodule : pmr_regs_bench
